// *** bench/lptk_osc_model.sv ***
`timescale 1ns/1ns
module lptk_osc_model (
	// controls
	input  wire logic clk,
	input  wire logic xt_run,
	input  wire logic ext_run,
	// pins
	output logic      slow_osc_in,
	output logic      xtal_in,
	output logic      ext_count_in
);
	int n = 0;
	initial {slow_osc_in, xtal_in, ext_count_in} = 3'h0;
	always @(posedge clk) begin
		n <= n + 1;
		if (n % 5 == 0)
			slow_osc_in <= ~slow_osc_in;
		if (xt_run && n % 3 == 0)
			xtal_in <= ~xtal_in;
		if (ext_run && n % 8 == 0)
			ext_count_in <= ~ext_count_in;
	end
endmodule // lptk_osc_model

// *** bench/lptk_sva.sv ***
`timescale 1ns/1ns
module lptk_sva (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	// pins
	input wire logic [3:0]  xtal_load_trim,
	input wire logic        slow_osc_in,
	input wire logic        slow_clk_out,
	input wire logic        tap_out,
	input wire logic        tap_oe,
	input wire logic        sq_out,
	// requests
	input wire logic        irq,
	input wire logic        reset_req,
	input wire logic        wakeup_req
);
	logic wr;
	logic wr_ctrl;
	assign wr = psel && pwrite;
	assign wr_ctrl = wr && penable && paddr == 8'h00;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	trim_tracks_a: assert property (wr_ctrl |=>
		xtal_load_trim == $past(pwdata[15:12])) else $error("trim");
	tap_quiet_a: assert property (!tap_oe |-> !tap_out)
		else $error("tap level");
	tap_cause_a: assert property ($rose(tap_oe) |->
		$past(wr_ctrl) || $past(wr_ctrl, 2)) else $error("tap enable");
	slow_pass_a: assert property ($rose(slow_osc_in) |->
		##[1:4] $rose(slow_clk_out)) else $error("slow clock");
	irq_hold_a: assert property (irq && !wr && !$past(wr) |=> irq)
		else $error("irq dropped");
	rreq_hold_a: assert property (reset_req && !wr && !$past(wr)
		|=> reset_req) else $error("reset request dropped");
	wake_hold_a: assert property (wakeup_req && !wr && !$past(wr)
		|=> wakeup_req) else $error("wakeup request dropped");
	sq_steady_a: assert property ($changed(sq_out) |=>
		$stable(sq_out)) else $error("square wave");
endmodule // lptk_sva
bind lptk_top lptk_sva u_sva (.clk(clk), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.xtal_load_trim(xtal_load_trim), .slow_osc_in(slow_osc_in),
	.slow_clk_out(slow_clk_out), .tap_out(tap_out), .tap_oe(tap_oe),
	.sq_out(sq_out), .irq(irq), .reset_req(reset_req),
	.wakeup_req(wakeup_req));

// *** bench/test_low_power_timekeeping.sv ***
`timescale 1ns/1ns
module test_low_power_timekeeping import lptk_pkg::*;;
	logic        clk, rst, psel, penable, pwrite, xt_run, ext_run;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r, d;
	logic [3:0]  trim;
	logic        pready, pslverr, err, slow_in, xt_in, ext_in, slow_out;
	logic        tap_out, tap_oe, sq_out, pwm_out, irq, rreq, wreq;
	int          n_errors, cmp_count, hi, sq_n, tap_n;
	lptk_top #(.MCD_CYCLES(20), .SCW(4)) u_dut (.clk(clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .slow_osc_in(slow_in), .xtal_in(xt_in),
		.ext_count_in(ext_in), .xtal_load_trim(trim),
		.slow_clk_out(slow_out), .tap_out(tap_out), .tap_oe(tap_oe),
		.sq_out(sq_out), .pwm_out(pwm_out), .irq(irq),
		.reset_req(rreq), .wakeup_req(wreq));
	lptk_osc_model u_osc (.clk(clk), .xt_run(xt_run), .ext_run(ext_run),
		.slow_osc_in(slow_in), .xtal_in(xt_in), .ext_count_in(ext_in));
	always @(posedge clk) begin
		if ($changed(sq_out))
			sq_n <= sq_n + 1;
		if ($changed(tap_out))
			tap_n <= tap_n + 1;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch at %0t: %h vs %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] v);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		apb(1'b1, a, v);
	endtask
	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic print_verdict;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#100000;
		n_errors++;
		print_verdict();
	end
	initial begin
		{psel, penable, pwrite, ext_run, paddr, pwdata} = '0;
		{rst, xt_run} = 2'h3;
		{n_errors, cmp_count, sq_n, tap_n} = '0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(8'h00);
		chk(r, LPTK_CTRL_RST);
		rd(8'h40);
		chk({err, r[30:0]}, 32'h8000_0000);
		wr(8'h00, 32'hA007);
		chk({trim, tap_oe}, 5'h15);
		rd(8'h04);
		d = r;
		hi = tap_n;
		repeat (60) @(posedge clk);
		rd(8'h04);
		chk(32'(r - d > 32'h7 && r - d < 32'hF), 32'h1);
		chk(32'(tap_n - hi > 15), 32'h1);
		for (int i = 0; i < 3; i++)
			wr(8'(8'h08 + 4 * i), 32'(30 + i));
		wr(8'h2C, 32'h1);
		wr(8'h30, 32'h2);
		wr(8'h34, 32'h4);
		wr(8'h28, 32'h3F);
		wr(8'h04, 32'h0);
		repeat (220) @(posedge clk);
		rd(8'h24);
		chk(r, 32'h7);
		chk({irq, rreq, wreq}, 3'h7);
		wr(8'h28, 32'h1);
		rd(8'h24);
		chk({r[5:0], irq, rreq, wreq}, 9'h33);
		wr(8'h08, 32'h5);
		wr(8'h00, 32'hB);
		wr(8'h04, 32'h0);
		repeat (100) @(posedge clk);
		rd(8'h04);
		chk(32'(r < 32'h6), 32'h1);
		wr(8'h00, 32'h103);
		wr(8'h28, 32'h3F);
		xt_run <= 1'b0;
		repeat (60) @(posedge clk);
		rd(8'h24);
		chk(r[3], 1'b1);
		xt_run <= 1'b1;
		wr(8'h14, 32'h3);
		for (int f = 0; f < 2; f++) begin
			wr(8'h00, 32'hB1 | 32'(f << 6));
			wr(8'h28, 32'h3F);
			hi = sq_n;
			ext_run <= 1'b1;
			repeat (150) @(posedge clk);
			ext_run <= 1'b0;
			rd(8'h24);
			chk(32'(r[5:4] == 2'h2 && sq_n - hi > 1), 32'h1);
		end
		wr(8'h00, 32'h13);
		wr(8'h28, 32'h3F);
		repeat (150) @(posedge clk);
		rd(8'h24);
		chk(r[5:4], 2'h3);
		wr(8'h20, 32'h9);
		rd(8'h20);
		chk(32'(r == 32'h9 || r == 32'hA), 32'h1);
		rd(8'h14);
		chk(r, 32'h3);
		wr(8'h18, 32'h3);
		for (int k = 0; k < 2; k++) begin
			wr(8'h1C, 32'(2 * k));
			hi = 0;
			repeat (96) begin
				@(posedge clk);
				hi += int'(pwm_out === 1'b1);
			end
			chk(32'(hi >= 36 * k && hi < 1 + 60 * k), 32'h1);
		end
		print_verdict();
	end
endmodule // test_low_power_timekeeping

// *** common/lptk_pkg.sv ***
// Summary of operation
// R01: rtc keeps time in a 32-bit up counter on the timekeeping clock
// R02: three alarm events plus a missing-clock event
// R03: each event routable to interrupt, reset request or wakeup request
// R04: alarm 0 may clear the rtc counter on match for periodic alarms
// R05: 4-bit crystal load setting, 16 levels, drives oscillator trim
// R06: timekeeping clock selects internal slow oscillator or 32.768 kHz crystal
// R07: clock tap drives a pin when enabled, also in deepest sleep state
// R08: slow internal oscillator is offered to other modules as a clock
// R09: sleep counter runs only on the timekeeping clock enable; with external select it counts external input edges instead
// R10: sleep counter counts clock ticks or chosen edge of external input
// R11: sleep counter flags overflow and threshold match
// R12: optional clear on threshold match gives a square wave output
// R13: pwm output with programmable period and duty
// R14: alarm raised in the tick where rtc counter equals compare value
// R15: event flags sticky until cleared; pin inputs synchronised first
package lptk_pkg;
	localparam logic [7:0] LPTK_CTRL_OFS    = 8'h00;
	localparam logic [7:0] LPTK_RTC_OFS     = 8'h04;
	localparam logic [7:0] LPTK_ALM0_OFS    = 8'h08;
	localparam logic [7:0] LPTK_ALM1_OFS    = 8'h0C;
	localparam logic [7:0] LPTK_ALM2_OFS    = 8'h10;
	localparam logic [7:0] LPTK_THR_OFS     = 8'h14;
	localparam logic [7:0] LPTK_PER_OFS     = 8'h18;
	localparam logic [7:0] LPTK_DUTY_OFS    = 8'h1C;
	localparam logic [7:0] LPTK_SCNT_OFS    = 8'h20;
	localparam logic [7:0] LPTK_STAT_OFS    = 8'h24;
	localparam logic [7:0] LPTK_CLR_OFS     = 8'h28;
	localparam logic [7:0] LPTK_IEN_OFS     = 8'h2C;
	localparam logic [7:0] LPTK_RSTEN_OFS   = 8'h30;
	localparam logic [7:0] LPTK_WKEN_OFS    = 8'h34;
	// ctrl fields
	localparam int LPTK_C_RTC_EN   = 0;
	localparam int LPTK_C_XTAL_SEL = 1;
	localparam int LPTK_C_TAP_EN   = 2;
	localparam int LPTK_C_AUTOCLR  = 3;
	localparam int LPTK_C_SC_EN    = 4;
	localparam int LPTK_C_EXT_SEL  = 5;
	localparam int LPTK_C_FALL     = 6;
	localparam int LPTK_C_THR_CLR  = 7;
	localparam int LPTK_C_MCD_EN   = 8;
	localparam int LPTK_C_LOAD_LO  = 12;
	localparam int LPTK_C_LOAD_W   = 4;
	localparam logic [31:0] LPTK_CTRL_RST = 32'h0000_0000;
	// status bits
	localparam int LPTK_EV_N    = 6;
	localparam int LPTK_EV_ALM0 = 0;
	localparam int LPTK_EV_MCD  = 3;
	localparam int LPTK_EV_OVF  = 4;
	localparam int LPTK_EV_THR  = 5;
	// missing-clock window in system clocks
	localparam int LPTK_CLK_MHZ    = 100;
	localparam int LPTK_MCD_US     = 1000;
	localparam int LPTK_MCD_CYCLES = LPTK_MCD_US * LPTK_CLK_MHZ;
endpackage

// *** common/lptk_tick_if.sv ***
`timescale 1ns/1ns
interface lptk_tick_if;
	logic sync_lf;
	logic sync_xt;
	logic xtal_sel;
	logic tick;
	logic tap;
	modport src (input sync_lf, input sync_xt, input xtal_sel,
		output tick, output tap);
	modport dst (output sync_lf, output sync_xt, output xtal_sel,
		input tick, input tap);
endinterface

// *** hdl/lptk_sync.sv ***
`timescale 1ns/1ns
module lptk_sync #(
	parameter int W = 3
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} lptk_sync_s;
	lptk_sync_s st_q;
	lptk_sync_s st_d;
	always_comb begin
		st_d    = st_q;
		st_d.s1 = d;
		st_d.s2 = st_q.s1; // R15
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	assign q = st_q.s2;
endmodule // lptk_sync

// *** hdl/lptk_tick.sv ***
`timescale 1ns/1ns
module lptk_tick (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// tick link
	lptk_tick_if.src  t
);
	typedef struct packed {
		logic prev;
		logic tick;
	} lptk_tick_s;
	lptk_tick_s st_q;
	lptk_tick_s st_d;
	logic       sel;
	always_comb begin
		sel = t.xtal_sel ? t.sync_xt : t.sync_lf; // R06
		st_d = st_q;
		st_d.prev = sel;
		st_d.tick = sel & ~st_q.prev;
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	assign t.tick = st_q.tick;
	assign t.tap  = st_q.prev;
endmodule // lptk_tick

// *** hdl/lptk_top.sv ***
`timescale 1ns/1ns
module lptk_top
	import lptk_pkg::*;
#(
	parameter int MCD_CYCLES = LPTK_MCD_CYCLES,
	parameter int SCW        = 16
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// oscillator pins
	input  wire logic        slow_osc_in,
	input  wire logic        xtal_in,
	input  wire logic        ext_count_in,
	output logic      [3:0]  xtal_load_trim,
	output logic             slow_clk_out,
	// pin outputs
	output logic             tap_out,
	output logic             tap_oe,
	output logic             sq_out,
	output logic             pwm_out,
	// requests
	output logic             irq,
	output logic             reset_req,
	output logic             wakeup_req
);
	typedef struct packed {
		logic [31:0]         ctrl;
		logic [31:0]         rtc;
		logic [2:0][31:0]    alm;
		logic [SCW-1:0]      thr;
		logic [SCW-1:0]      per;
		logic [SCW-1:0]      duty;
		logic [SCW-1:0]      scnt;
		logic [SCW-1:0]      pcnt;
		logic [LPTK_EV_N-1:0] stat;
		logic [LPTK_EV_N-1:0] ien;
		logic [LPTK_EV_N-1:0] rsten;
		logic [LPTK_EV_N-1:0] wken;
		logic [31:0]         mcd;
		logic                ext_prev;
		logic                sq;
		logic                pwm;
		logic [31:0]         rdata;
	} lptk_top_s;
	lptk_top_s st_q;
	lptk_top_s st_d;

	logic [2:0]           pins;
	logic                 tick;
	logic                 ext_edge;
	logic                 sc_inc;
	logic [LPTK_EV_N-1:0] ev;
	logic                 wr;
	logic                 rd;
	logic                 hit;
	logic [2:0]           alm_hit;
	lptk_tick_if          tk ();

	lptk_sync #(.W(3)) u_sync (
		.clk (clk),
		.rst (rst),
		.d   ({ext_count_in, xtal_in, slow_osc_in}),
		.q   (pins)
	);

	assign tk.sync_lf  = pins[0];
	assign tk.sync_xt  = pins[1];
	assign tk.xtal_sel = st_q.ctrl[LPTK_C_XTAL_SEL]; // R06

	lptk_tick u_tick (
		.clk (clk),
		.rst (rst),
		.t   (tk)
	);

	assign tick = tk.tick;
	assign wr   = psel & penable & pwrite;
	assign rd   = psel & ~penable & ~pwrite;

	// one compare per alarm
	for (genvar g = 0; g < 3; g++) begin : g_alm
		assign alm_hit[g] = (st_q.rtc == st_q.alm[g]); // R14
	end

	always_comb begin
		hit = 1'b1;
		unique case (paddr)
			LPTK_CTRL_OFS, LPTK_RTC_OFS, LPTK_ALM0_OFS, LPTK_ALM1_OFS,
			LPTK_ALM2_OFS, LPTK_THR_OFS, LPTK_PER_OFS, LPTK_DUTY_OFS,
			LPTK_SCNT_OFS, LPTK_STAT_OFS, LPTK_CLR_OFS, LPTK_IEN_OFS,
			LPTK_RSTEN_OFS, LPTK_WKEN_OFS: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	always_comb begin
		st_d = st_q;
		ev   = '0;
		// rtc counter and alarms
		if (st_q.ctrl[LPTK_C_RTC_EN] && tick) begin
			ev[LPTK_EV_ALM0 +: 3] = alm_hit; // R14 R02
			if (ev[LPTK_EV_ALM0] && st_q.ctrl[LPTK_C_AUTOCLR]) begin
				st_d.rtc = '0; // R04
			end else begin
				st_d.rtc = st_q.rtc + 32'h0000_0001; // R01
			end
		end
		// missing clock detector
		if (tick || !st_q.ctrl[LPTK_C_MCD_EN]) begin
			st_d.mcd = '0;
		end else if (st_q.mcd == 32'(MCD_CYCLES - 1)) begin
			ev[LPTK_EV_MCD] = 1'b1; // R02
			st_d.mcd = '0;
		end else begin
			st_d.mcd = st_q.mcd + 32'h0000_0001;
		end
		// sleep counter
		st_d.ext_prev = pins[2];
		ext_edge = st_q.ctrl[LPTK_C_FALL] ? (st_q.ext_prev & ~pins[2])
			: (~st_q.ext_prev & pins[2]); // R10
		sc_inc = st_q.ctrl[LPTK_C_EXT_SEL] ? ext_edge : tick; // R10 R09
		if (st_q.ctrl[LPTK_C_SC_EN] && sc_inc) begin
			if (st_q.scnt == st_q.thr) begin
				ev[LPTK_EV_THR] = 1'b1; // R11
			end
			if (&st_q.scnt) begin
				ev[LPTK_EV_OVF] = 1'b1; // R11
			end
			if (ev[LPTK_EV_THR] && st_q.ctrl[LPTK_C_THR_CLR]) begin
				st_d.scnt = '0; // R12
				st_d.sq   = ~st_q.sq; // R12
			end else begin
				st_d.scnt = st_q.scnt + 1'b1;
			end
		end
		// pwm on ticks
		if (st_q.ctrl[LPTK_C_SC_EN] && tick) begin
			if (st_q.pcnt >= st_q.per) begin
				st_d.pcnt = '0; // R13
			end else begin
				st_d.pcnt = st_q.pcnt + 1'b1;
			end
			st_d.pwm = (st_d.pcnt < st_q.duty); // R13
		end
		// register writes
		if (wr) begin
			unique case (paddr)
				LPTK_CTRL_OFS:  st_d.ctrl = pwdata;
				LPTK_RTC_OFS:   st_d.rtc = pwdata;
				LPTK_ALM0_OFS:  st_d.alm[0] = pwdata;
				LPTK_ALM1_OFS:  st_d.alm[1] = pwdata;
				LPTK_ALM2_OFS:  st_d.alm[2] = pwdata;
				LPTK_THR_OFS:   st_d.thr = pwdata[SCW-1:0];
				LPTK_PER_OFS:   st_d.per = pwdata[SCW-1:0];
				LPTK_DUTY_OFS:  st_d.duty = pwdata[SCW-1:0];
				LPTK_SCNT_OFS:  st_d.scnt = pwdata[SCW-1:0];
				LPTK_CLR_OFS:   st_d.stat = st_q.stat & ~pwdata[LPTK_EV_N-1:0];
				LPTK_IEN_OFS:   st_d.ien = pwdata[LPTK_EV_N-1:0];
				LPTK_RSTEN_OFS: st_d.rsten = pwdata[LPTK_EV_N-1:0];
				LPTK_WKEN_OFS:  st_d.wken = pwdata[LPTK_EV_N-1:0];
				default: ;
			endcase
		end
		st_d.stat = st_d.stat | ev; // R15
		// read data captured in setup phase
		if (rd) begin
			unique case (paddr)
				LPTK_CTRL_OFS:  st_d.rdata = st_q.ctrl;
				LPTK_RTC_OFS:   st_d.rdata = st_q.rtc;
				LPTK_ALM0_OFS:  st_d.rdata = st_q.alm[0];
				LPTK_ALM1_OFS:  st_d.rdata = st_q.alm[1];
				LPTK_ALM2_OFS:  st_d.rdata = st_q.alm[2];
				LPTK_THR_OFS:   st_d.rdata = 32'(st_q.thr);
				LPTK_PER_OFS:   st_d.rdata = 32'(st_q.per);
				LPTK_DUTY_OFS:  st_d.rdata = 32'(st_q.duty);
				LPTK_SCNT_OFS:  st_d.rdata = 32'(st_q.scnt);
				LPTK_STAT_OFS:  st_d.rdata = 32'(st_q.stat);
				LPTK_IEN_OFS:   st_d.rdata = 32'(st_q.ien);
				LPTK_RSTEN_OFS: st_d.rdata = 32'(st_q.rsten);
				LPTK_WKEN_OFS:  st_d.rdata = 32'(st_q.wken);
				default:        st_d.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q      <= '0;
			st_q.ctrl <= LPTK_CTRL_RST;
		end else begin
			st_q <= st_d;
		end
	end

	assign prdata     = st_q.rdata;
	assign pready     = 1'b1;
	assign pslverr    = psel & penable & ~hit;
	assign xtal_load_trim =
		st_q.ctrl[LPTK_C_LOAD_LO +: LPTK_C_LOAD_W]; // R05
	assign slow_clk_out = pins[0]; // R08
	assign tap_oe     = st_q.ctrl[LPTK_C_TAP_EN]; // R07
	assign tap_out    = tap_oe & tk.tap; // R07
	assign sq_out     = st_q.sq;
	assign pwm_out    = st_q.pwm;
	assign irq        = |(st_q.stat & st_q.ien); // R03
	assign reset_req  = |(st_q.stat & st_q.rsten); // R03
	assign wakeup_req = |(st_q.stat & st_q.wken); // R03
endmodule // lptk_top
